/* File: design/ifpr_defs.vh */
// Purpose: constants for the interrupt flag and priority register block
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   offsets are byte addresses
`ifndef IFPR_DEFS_VH
`define IFPR_DEFS_VH

`define IFPR_OFF_EDGE_PRIO   12'h000
`define IFPR_OFF_EXT_IRQ     12'h004
`define IFPR_OFF_FLAGS_ONE   12'h008
`define IFPR_OFF_FLAGS_TWO   12'h00c
`define IFPR_OFF_PIE_ONE     12'h010
`define IFPR_OFF_PIE_TWO     12'h014
`define IFPR_OFF_CORE_CTRL   12'h018
`define IFPR_OFF_STATUS      12'h01c

// reset values
`define IFPR_RST_EDGE_PRIO   8'hf5
`define IFPR_RST_EXT_IRQ     8'hc0
`define IFPR_RST_ZERO        8'h00

// writable masks; unimplemented positions read zero
`define IFPR_MASK_EDGE_PRIO  8'hf5
`define IFPR_MASK_EXT_IRQ    8'hdb
`define IFPR_MASK_FLAGS_ONE  8'hff
`define IFPR_MASK_FLAGS_TWO  5'h1f
`define IFPR_MASK_CORE_CTRL  8'h07

// field positions, edge and priority control
`define IFPR_B_PULLUP_DIS    7
`define IFPR_B_EDGE0         6
`define IFPR_B_EDGE1         5
`define IFPR_B_EDGE2         4
`define IFPR_B_TMR0_PRIO     2
`define IFPR_B_PORTCH_PRIO   0
// external interrupt control
`define IFPR_B_EXT2_PRIO     7
`define IFPR_B_EXT1_PRIO     6
`define IFPR_B_EXT2_EN       4
`define IFPR_B_EXT1_EN       3
`define IFPR_B_EXT2_FLAG     1
`define IFPR_B_EXT1_FLAG     0
// flags one
`define IFPR_B_PSP           7
`define IFPR_B_ADC           6
`define IFPR_B_RX_FULL       5
`define IFPR_B_TX_EMPTY      4
`define IFPR_B_SSP           3
`define IFPR_B_CCP1          2
`define IFPR_B_TMR2          1
`define IFPR_B_TMR1          0
// flags two
`define IFPR_B_NVM           4
`define IFPR_B_BCL           3
`define IFPR_B_LVD           2
`define IFPR_B_TMR3          1
`define IFPR_B_CCP2          0
// core control: global enables and priority mode
`define IFPR_B_GIE_HIGH      0
`define IFPR_B_GIE_LOW       1
`define IFPR_B_PRIO_MODE     2

`define IFPR_SLVERR_UNMAPPED 1'b1

`endif

/* File: design/ifpr_edge_detect.v */
// Purpose: synchronise one external interrupt pin and detect selected edge
// Assumes: pin is asynchronous to mclk
// Notes:   one-cycle pulse output
`timescale 1ns/100ps
module ifpr_edge_detect (
   // clock and reset
   input  wire mclk,
   input  wire rst_n,
   // pin and edge choice
   input  wire pin_in,
   input  wire rising_sel,
   // event
   output reg  edge_pulse
);
   reg       sync1_r;
   reg       sync2_r;
   reg       last_r;
   reg [2:0] armed_r;

   // edges count only once last_r holds a real sample, so a pin
   // that idles high cannot fake a rising edge right after reset
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r    <= 1'b0;
         sync2_r    <= 1'b0;
         last_r     <= 1'b0;
         armed_r    <= 3'h0;
         edge_pulse <= 1'b0;
      end else begin
         sync1_r    <= pin_in;
         sync2_r    <= sync1_r;
         last_r     <= sync2_r;
         armed_r    <= {armed_r[1:0], 1'b1};
         // 1 picks rising, 0 falling
         edge_pulse <= armed_r[2] &
                       (rising_sel ? (sync2_r & ~last_r) : (~sync2_r & last_r));
      end
   end
endmodule // ifpr_edge_detect

/* File: design/ifpr_regs.v */
// Purpose: edge/priority control, external irq control and peripheral flag registers
// Assumes: apb slave, event strobes are one-cycle pulses on mclk
// Notes:   hardware set wins over a software clear in the same cycle
`timescale 1ns/100ps
`include "ifpr_defs.vh"

//////////////////////////////////////////////////////////////////////////////
module ifpr_regs (
   // clock and reset
   input  wire        mclk,
   input  wire        reset_n,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output wire        pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   // external interrupt pins
   input  wire        ext_irq1_pin,
   input  wire        ext_irq2_pin,
   // peripheral event strobes, serial buffer levels and pwm mode selects
   input  wire        psp_access_evt,
   input  wire        adc_done_evt,
   input  wire        serial_rx_full,
   input  wire        serial_tx_empty,
   input  wire        ssp_done_evt,
   input  wire        ccp1_evt,
   input  wire        ccp1_pwm_mode,
   input  wire        timer2_match_evt,
   input  wire        timer1_ovf_evt,
   input  wire        nvm_write_done_evt,
   input  wire        bus_collision_evt,
   input  wire        low_voltage_evt,
   input  wire        timer3_ovf_evt,
   input  wire        ccp2_evt,
   input  wire        ccp2_pwm_mode,
   // control outputs
   output reg         port_b_pullup_disable,
   output reg         ext_irq0_edge_select,
   output reg         timer0_overflow_priority,
   output reg         port_change_priority,
   output reg         priority_mode_enable,
   output reg  [7:0]  flags_one_out,
   output reg  [4:0]  flags_two_out,
   // vector requests
   output reg         irq_high_req,
   output reg         irq_low_req
);

   //////////////////////////////////////////////////////////////////////////
   // reset release
   reg rst_s1_r;
   reg rst_n_r;
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // registers
   reg [7:0] edge_priority_control_r;
   reg [7:0] external_irq_control_r;
   reg [7:0] flags_one_r;       // bits 5,4 unused: live status instead
   reg [4:0] flags_two_r;
   reg [7:0] pie_one_r;
   reg [4:0] pie_two_r;
   reg [7:0] core_ctrl_r;

   wire ext_irq1_edge_select = edge_priority_control_r[`IFPR_B_EDGE1];
   wire ext_irq2_edge_select = edge_priority_control_r[`IFPR_B_EDGE2];
   wire ext1_evt;
   wire ext2_evt;

   ifpr_edge_detect u_ext1 (
      .mclk       (mclk),
      .rst_n      (rst_n_r),
      .pin_in     (ext_irq1_pin),
      .rising_sel (ext_irq1_edge_select),
      .edge_pulse (ext1_evt)
   );

   ifpr_edge_detect u_ext2 (
      .mclk       (mclk),
      .rst_n      (rst_n_r),
      .pin_in     (ext_irq2_pin),
      .rising_sel (ext_irq2_edge_select),
      .edge_pulse (ext2_evt)
   );

   //////////////////////////////////////////////////////////////////////////
   // apb decode; zero wait states
   assign pready = 1'b1;
   wire       wr_en  = psel & penable & pwrite & pstrb[0];
   wire       rd_acc = psel & ~pwrite;
   wire [7:0] wbyte  = pwdata[7:0];

   // one write strobe per register except status; only byte lane 0 is wired
   wire wr_edge  = wr_en & (paddr == `IFPR_OFF_EDGE_PRIO);
   wire wr_ext   = wr_en & (paddr == `IFPR_OFF_EXT_IRQ);
   wire wr_f1    = wr_en & (paddr == `IFPR_OFF_FLAGS_ONE);
   wire wr_f2    = wr_en & (paddr == `IFPR_OFF_FLAGS_TWO);
   wire wr_pie1  = wr_en & (paddr == `IFPR_OFF_PIE_ONE);
   wire wr_pie2  = wr_en & (paddr == `IFPR_OFF_PIE_TWO);
   wire wr_core  = wr_en & (paddr == `IFPR_OFF_CORE_CTRL);
   wire mapped   = (paddr == `IFPR_OFF_EDGE_PRIO) | (paddr == `IFPR_OFF_EXT_IRQ) |
                   (paddr == `IFPR_OFF_FLAGS_ONE) | (paddr == `IFPR_OFF_FLAGS_TWO) |
                   (paddr == `IFPR_OFF_PIE_ONE)   | (paddr == `IFPR_OFF_PIE_TWO) |
                   (paddr == `IFPR_OFF_CORE_CTRL) | (paddr == `IFPR_OFF_STATUS);

   // hardware set terms; pwm mode masks capture/compare strobes
   wire [7:0] set_one;
   assign set_one[`IFPR_B_PSP]      = psp_access_evt;
   assign set_one[`IFPR_B_ADC]      = adc_done_evt;
   assign set_one[`IFPR_B_RX_FULL]  = 1'b0;
   assign set_one[`IFPR_B_TX_EMPTY] = 1'b0;
   assign set_one[`IFPR_B_SSP]      = ssp_done_evt;
   assign set_one[`IFPR_B_CCP1]     = ccp1_evt & ~ccp1_pwm_mode;
   assign set_one[`IFPR_B_TMR2]     = timer2_match_evt;
   assign set_one[`IFPR_B_TMR1]     = timer1_ovf_evt;

   wire [4:0] set_two;
   assign set_two[`IFPR_B_NVM]  = nvm_write_done_evt;
   assign set_two[`IFPR_B_BCL]  = bus_collision_evt;
   assign set_two[`IFPR_B_LVD]  = low_voltage_evt;
   assign set_two[`IFPR_B_TMR3] = timer3_ovf_evt;
   assign set_two[`IFPR_B_CCP2] = ccp2_evt & ~ccp2_pwm_mode;

   wire [7:0] ext_set = {6'h00, ext2_evt, ext1_evt};

   //////////////////////////////////////////////////////////////////////////
   // register updates
   reg [7:0] edge_priority_control_nxt;
   reg [7:0] external_irq_control_nxt;
   reg [7:0] flags_one_nxt;
   reg [4:0] flags_two_nxt;
   reg [7:0] pie_one_nxt;
   reg [4:0] pie_two_nxt;
   reg [7:0] core_ctrl_nxt;

   // the write lands first and the hardware set is or-ed in after it,
   // so an event in the cycle of a software clear is never lost
   always @* begin
      edge_priority_control_nxt = edge_priority_control_r;
      external_irq_control_nxt  = external_irq_control_r;
      flags_one_nxt             = flags_one_r;
      flags_two_nxt             = flags_two_r;
      pie_one_nxt               = pie_one_r;
      pie_two_nxt               = pie_two_r;
      core_ctrl_nxt             = core_ctrl_r;

      if (wr_edge)
         edge_priority_control_nxt = wbyte & `IFPR_MASK_EDGE_PRIO;

      if (wr_ext)
         external_irq_control_nxt = wbyte & `IFPR_MASK_EXT_IRQ;

      if (wr_f1)
         flags_one_nxt = wbyte & `IFPR_MASK_FLAGS_ONE;

      if (wr_f2)
         flags_two_nxt = wbyte[4:0] & `IFPR_MASK_FLAGS_TWO;

      if (wr_pie1)
         pie_one_nxt = wbyte;

      if (wr_pie2)
         pie_two_nxt = wbyte[4:0];

      if (wr_core)
         core_ctrl_nxt = wbyte & `IFPR_MASK_CORE_CTRL;

      external_irq_control_nxt = external_irq_control_nxt | ext_set;
      flags_one_nxt            = flags_one_nxt | set_one;
      flags_two_nxt            = flags_two_nxt | set_two;
   end

   // software-only registers
   always @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         edge_priority_control_r <= `IFPR_RST_EDGE_PRIO;
         pie_one_r               <= `IFPR_RST_ZERO;
         pie_two_r               <= 5'h00;
         core_ctrl_r             <= `IFPR_RST_ZERO;
      end else begin
         edge_priority_control_r <= edge_priority_control_nxt;
         pie_one_r               <= pie_one_nxt;
         pie_two_r               <= pie_two_nxt;
         core_ctrl_r             <= core_ctrl_nxt;
      end
   end

   // registers that hardware events also set
   always @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         external_irq_control_r  <= `IFPR_RST_EXT_IRQ;
         flags_one_r             <= `IFPR_RST_ZERO;
         flags_two_r             <= 5'h00;
      end else begin
         external_irq_control_r  <= external_irq_control_nxt;
         flags_one_r             <= flags_one_nxt;
         flags_two_r             <= flags_two_nxt;
      end
   end

   // serial status bits follow the buffer state, never stored
   // a buffer read or write clears them at the source, not here
   wire [7:0] flags_one_view;
   assign flags_one_view = {flags_one_r[7:6], serial_rx_full, serial_tx_empty,
                            flags_one_r[3:0]};

   //////////////////////////////////////////////////////////////////////////
   // read path, registered
   reg [31:0] rd_word_nxt;
   always @* begin
      rd_word_nxt = 32'h0000_0000;
      case (paddr)
         `IFPR_OFF_EDGE_PRIO: rd_word_nxt = {24'h000000, edge_priority_control_r};
         `IFPR_OFF_EXT_IRQ:   rd_word_nxt = {24'h000000, external_irq_control_r};
         `IFPR_OFF_FLAGS_ONE: rd_word_nxt = {24'h000000, flags_one_view};
         `IFPR_OFF_FLAGS_TWO: rd_word_nxt = {27'h0000000, flags_two_r};
         `IFPR_OFF_PIE_ONE:   rd_word_nxt = {24'h000000, pie_one_r};
         `IFPR_OFF_PIE_TWO:   rd_word_nxt = {27'h0000000, pie_two_r};
         `IFPR_OFF_CORE_CTRL: rd_word_nxt = {24'h000000, core_ctrl_r};
         `IFPR_OFF_STATUS:    rd_word_nxt = {30'h00000000, irq_low_req, irq_high_req};
         default:             rd_word_nxt = 32'h0000_0000;
      endcase
   end

   // data load at the setup edge and stand through the access phase
   always @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pslverr <= 1'b0;
         if (rd_acc & ~penable)
            prdata <= rd_word_nxt;
         if (psel & ~penable & ~mapped)
            pslverr <= `IFPR_SLVERR_UNMAPPED;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // vector request
   wire       prio_mode = core_ctrl_r[`IFPR_B_PRIO_MODE];
   wire       gie_h     = core_ctrl_r[`IFPR_B_GIE_HIGH];
   wire       gie_l     = core_ctrl_r[`IFPR_B_GIE_LOW];
   wire [7:0] act_one   = flags_one_view & pie_one_r;
   wire [4:0] act_two   = flags_two_r & pie_two_r;
   wire       act_e1    = external_irq_control_r[`IFPR_B_EXT1_FLAG] &
                          external_irq_control_r[`IFPR_B_EXT1_EN];
   wire       act_e2    = external_irq_control_r[`IFPR_B_EXT2_FLAG] &
                          external_irq_control_r[`IFPR_B_EXT2_EN];
   // peripheral priorities live elsewhere; external ones here
   wire ext_hi = (act_e1 & external_irq_control_r[`IFPR_B_EXT1_PRIO]) |
                 (act_e2 & external_irq_control_r[`IFPR_B_EXT2_PRIO]);
   wire ext_lo = (act_e1 & ~external_irq_control_r[`IFPR_B_EXT1_PRIO]) |
                 (act_e2 & ~external_irq_control_r[`IFPR_B_EXT2_PRIO]);
   wire periph = (|act_one) | (|act_two);
   reg  irq_high_nxt;
   reg  irq_low_nxt;

   // vector choice; priority bits count only in priority mode
   always @* begin
      if (prio_mode) begin
         irq_high_nxt = gie_h & ext_hi;
         irq_low_nxt  = gie_l & (ext_lo | periph);
      end else begin
         // compatibility: one vector, priority bits ignored
         irq_high_nxt = gie_h & ((act_e1 | act_e2) | (gie_l & periph));
         irq_low_nxt  = 1'b0;
      end
   end

   always @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_high_req <= 1'b0;
         irq_low_req  <= 1'b0;
      end else begin
         irq_high_req <= irq_high_nxt;
         irq_low_req  <= irq_low_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // control and flag outputs
   // outputs lag their registers by one edge
   always @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         port_b_pullup_disable    <= 1'b1;
         ext_irq0_edge_select     <= 1'b1;
         timer0_overflow_priority <= 1'b1;
         port_change_priority     <= 1'b1;
         priority_mode_enable     <= 1'b0;
         flags_one_out            <= `IFPR_RST_ZERO;
         flags_two_out            <= 5'h00;
      end else begin
         port_b_pullup_disable    <= edge_priority_control_r[`IFPR_B_PULLUP_DIS];
         ext_irq0_edge_select     <= edge_priority_control_r[`IFPR_B_EDGE0];
         timer0_overflow_priority <= edge_priority_control_r[`IFPR_B_TMR0_PRIO];
         port_change_priority     <= edge_priority_control_r[`IFPR_B_PORTCH_PRIO];
         priority_mode_enable     <= prio_mode;
         flags_one_out            <= flags_one_view;
         flags_two_out            <= flags_two_r;
      end
   end

endmodule // ifpr_regs

/* File: testbench/ifpr_periph_model.sv */
// Purpose: peripheral event sources facing the flag registers
// Assumes: bench requests are one mclk cycle wide
// Notes:   strobes leave one edge after the request
`timescale 1ns/100ps
module ifpr_periph_model (
   // clock
   input  wire       mclk,
   // bench requests
   input  wire [7:0] req1,
   input  wire [4:0] req2,
   // event strobes
   output reg  [7:0] ev1 = 8'h00,
   output reg  [4:0] ev2 = 5'h00
);
   // parallel port strobe only on request, so reduced-pin use keeps it clear
   always @(posedge mclk) begin
      ev1 <= req1 & 8'hcf; // rx full and tx empty are levels, never strobes
      ev2 <= req2;
   end
endmodule // ifpr_periph_model

/* File: testbench/ifpr_asserts.sv */
// Purpose: port checks for the flag and priority registers
// Assumes: zero-wait apb, an event reaches flags_one_out two edges later
// Notes:   bound into ifpr_regs below
`timescale 1ns/100ps
`include "ifpr_defs.vh"
module ifpr_asserts (
   // clock and reset
   input wire        mclk,
   input wire        reset_n,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0]  pstrb,
   input wire [31:0] prdata,
   // sources and outputs
   input wire        adc_done_evt,
   input wire        timer1_ovf_evt,
   input wire        serial_rx_full,
   input wire        serial_tx_empty,
   input wire        port_b_pullup_disable,
   input wire        ext_irq0_edge_select,
   input wire        timer0_overflow_priority,
   input wire [7:0]  flags_one_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire rd  = psel && penable && !pwrite;
   wire wr0 = psel && penable && pwrite && pstrb[0] && paddr == `IFPR_OFF_EDGE_PRIO;
   // outputs trail the register by one more edge
   sequence s_wr0; wr0 ##2 1'b1; endsequence
   sequence s_event(e); e ##2 1'b1; endsequence
   a_pullup_follows: assert property (
      s_wr0 |-> port_b_pullup_disable == $past(pwdata[7], 2))
      else $error("pull-up disable not taken from bit 7");
   a_edge0_follows: assert property (
      wr0 |-> ##2 ext_irq0_edge_select == $past(pwdata[6], 2))
      else $error("edge select 0 not taken from bit 6");
   a_t0prio_follows: assert property (
      wr0 |=> ##1 timer0_overflow_priority == $past(pwdata[2], 2))
      else $error("timer0 priority not taken from bit 2");
   a_reserved_zero: assert property (rd |->
      (paddr != `IFPR_OFF_EDGE_PRIO || (prdata[3] | prdata[1]) == 1'b0) &&
      (paddr != `IFPR_OFF_EXT_IRQ || (prdata[5] | prdata[2]) == 1'b0) &&
      (paddr != `IFPR_OFF_FLAGS_TWO || prdata[7:5] == 3'h0))
      else $error("unimplemented bit read as one");
   a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_timer1_flag: assert property (s_event(timer1_ovf_evt) |-> flags_one_out[0])
      else $error("timer1 overflow flag not set");
   a_adc_flag: assert property (s_event(adc_done_evt) |-> flags_one_out[6])
      else $error("conversion done flag not set");
   a_rx_level: assert property ($rose(serial_rx_full) |-> ##[1:2] flags_one_out[5])
      else $error("rx full flag does not follow buffer");
   a_tx_level: assert property ($fell(serial_tx_empty) |-> ##[1:2] !flags_one_out[4])
      else $error("tx empty flag does not follow buffer");
endmodule // ifpr_asserts
bind ifpr_regs ifpr_asserts ifpr_asserts_i (.mclk, .reset_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .adc_done_evt, .timer1_ovf_evt, .serial_rx_full,
   .serial_tx_empty, .port_b_pullup_disable, .ext_irq0_edge_select,
   .timer0_overflow_priority, .flags_one_out);

/* File: testbench/interrupt_flag_priority_regs_tb_top.sv */
// Purpose: self-checking bench for the flag and priority registers
// Assumes: zero-wait apb slave on a 40 MHz mclk
// Notes:   data from an xorshift seeded with 91
`timescale 1ns/100ps
`include "ifpr_defs.vh"
module interrupt_flag_priority_regs_tb_top;
   reg         mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0, seed = 32'h5b, rd, v;
   reg  [3:0]  pstrb = 4'h1;
   reg         ext_irq1_pin = 1'b0, ext_irq2_pin = 1'b0, err;
   reg         serial_rx_full = 1'b0, serial_tx_empty = 1'b0;
   reg         ccp1_pwm_mode = 1'b0, ccp2_pwm_mode = 1'b0;
   reg  [7:0]  req1 = 8'h00;
   reg  [4:0]  req2 = 5'h00;
   reg  [12:0] both;
   wire [7:0]  ev1, flags_one_out;
   wire [4:0]  ev2, flags_two_out;
   wire [31:0] prdata;
   wire        pready, pslverr, port_b_pullup_disable, ext_irq0_edge_select, irq_high_req;
   wire        timer0_overflow_priority, port_change_priority, priority_mode_enable, irq_low_req;
   integer     n_fail = 0, compares = 0, i, p;
   always #12.5 mclk = ~mclk;
   ifpr_periph_model ifpr_periph_model_i (.mclk, .req1, .req2, .ev1, .ev2);
   ifpr_regs ifpr_regs_i (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .pready, .prdata, .pslverr, .ext_irq1_pin, .ext_irq2_pin, .psp_access_evt(ev1[7]),
      .adc_done_evt(ev1[6]), .serial_rx_full, .serial_tx_empty, .ssp_done_evt(ev1[3]),
      .ccp1_evt(ev1[2]), .ccp1_pwm_mode, .timer2_match_evt(ev1[1]), .timer1_ovf_evt(ev1[0]),
      .nvm_write_done_evt(ev2[4]), .bus_collision_evt(ev2[3]), .low_voltage_evt(ev2[2]),
      .timer3_ovf_evt(ev2[1]), .ccp2_evt(ev2[0]), .ccp2_pwm_mode, .port_b_pullup_disable,
      .ext_irq0_edge_select, .timer0_overflow_priority, .port_change_priority,
      .priority_mode_enable, .flags_one_out, .flags_two_out, .irq_high_req, .irq_low_req);
   ///////////////////////////////////////////////////////////////////////////////////
   function [31:0] xs(input integer unused);
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         xs = seed;
      end
   endfunction
   // read-only rx/tx bits show the live levels, not the written data
   function [31:0] expect_rd(input [1:0] idx, input [7:0] w);
      case (idx)
         2'd0: expect_rd = w & 8'hf5;
         2'd1: expect_rd = w & 8'hdb;
         2'd2: expect_rd = (w & 8'hcf) | {serial_rx_full, serial_tx_empty, 4'h0};
         default: expect_rd = w & 8'h1f;
      endcase
   endfunction
   task end_of_test;
      begin
         $display("compares %0d n_fail %0d", compares, n_fail);
         if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task check(input string what, input [31:0] seen, input [31:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task apb(input [11:0] a, input w, input [31:0] d);
      integer k;
      begin
         @(posedge mclk);
         {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
         @(posedge mclk);
         penable <= 1'b1;
         k = 0;
         @(posedge mclk);
         while (pready !== 1'b1 && k < 20) begin
            @(posedge mclk);
            k = k + 1;
         end
         if (k == 20) begin
            n_fail = n_fail + 1;
            end_of_test;
         end
         rd = prdata;
         err = pslverr;
         {psel, penable} <= 2'b00;
      end
   endtask
   task fire(input [12:0] m);
      begin
         {req1, req2} <= m;
         @(posedge mclk);
         {req1, req2} <= 13'h0000;
         repeat (4) @(posedge mclk);
      end
   endtask
   ///////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      for (i = 0; i < 4; i = i + 1) begin
         apb({i[9:0], 2'b00}, 1'b0, 32'h0);
         check("reset value", rd, i == 0 ? 32'hf5 : (i == 1 ? 32'hc0 : 32'h0));
      end
      check("reset levels", {port_b_pullup_disable, ext_irq0_edge_select,
         timer0_overflow_priority, port_change_priority}, 32'hf);
      $display("test reset done");
      for (i = 0; i < 16; i = i + 1) begin
         v = xs(0);
         serial_rx_full <= v[16];
         serial_tx_empty <= v[17];
         apb({8'h00, v[9:8], 2'b00}, 1'b1, v);
         apb({8'h00, v[9:8], 2'b00}, 1'b0, 32'h0);
         check("random rw", rd, expect_rd(v[9:8], v[7:0]));
      end
      $display("test random done");
      // edge 1 rising, edge 2 falling; a write with lane 0 off must not land
      apb(`IFPR_OFF_EDGE_PRIO, 1'b1, 32'ha0);
      pstrb <= 4'h0;
      apb(`IFPR_OFF_EDGE_PRIO, 1'b1, 32'hff);
      pstrb <= 4'h1;
      apb(`IFPR_OFF_EDGE_PRIO, 1'b0, 32'h0);
      check("lane off", rd, 32'ha0);
      check("pin levels", {port_b_pullup_disable, ext_irq0_edge_select, timer0_overflow_priority,
         port_change_priority}, 32'h8);
      apb(`IFPR_OFF_EXT_IRQ, 1'b1, 32'h0);
      {ext_irq1_pin, ext_irq2_pin} <= 2'b11;
      repeat (8) @(posedge mclk);
      apb(`IFPR_OFF_EXT_IRQ, 1'b0, 32'h0);
      check("ext rise", rd, 32'h01);
      {ext_irq1_pin, ext_irq2_pin} <= 2'b00;
      repeat (8) @(posedge mclk);
      apb(`IFPR_OFF_EXT_IRQ, 1'b0, 32'h0);
      check("ext fall", rd, 32'h03);
      $display("test pins done");
      {serial_rx_full, serial_tx_empty} <= 2'b00;
      for (p = 0; p < 2; p = p + 1) begin
         {ccp1_pwm_mode, ccp2_pwm_mode} <= {p[0], p[0]};
         for (i = 0; i < 13; i = i + 1) begin
            if (i != 9 && i != 10) begin
               apb(`IFPR_OFF_FLAGS_ONE, 1'b1, 32'h0);
               apb(`IFPR_OFF_FLAGS_TWO, 1'b1, 32'h0);
               fire(13'h0001 << i);
               both = (p == 1 && (i == 0 || i == 7)) ? 13'h0000 : 13'h0001 << i;
               check("flag out", {flags_one_out, flags_two_out}, both);
               apb(`IFPR_OFF_FLAGS_ONE, 1'b0, 32'h0);
               v = rd;
               apb(`IFPR_OFF_FLAGS_TWO, 1'b0, 32'h0);
               check("flag one", v[7:0], both[12:5]);
               check("flag two", rd[4:0], both[4:0]);
            end
         end
      end
      $display("test flags done");
      apb(`IFPR_OFF_FLAGS_ONE, 1'b1, 32'h0);
      apb(`IFPR_OFF_PIE_ONE, 1'b1, 32'h40);
      apb(`IFPR_OFF_CORE_CTRL, 1'b1, 32'h3);
      fire(13'h0800);
      apb(`IFPR_OFF_STATUS, 1'b0, 32'h0);
      check("compat request", rd, 32'h1);
      apb(`IFPR_OFF_CORE_CTRL, 1'b1, 32'h7);
      repeat (3) @(posedge mclk);
      apb(`IFPR_OFF_STATUS, 1'b0, 32'h0);
      check("prio request", rd, 32'h2);
      check("prio mode", {priority_mode_enable, irq_high_req, irq_low_req}, 32'h5);
      // ext irq 1 enabled with its flag set: high priority first, then low
      apb(`IFPR_OFF_EXT_IRQ, 1'b1, 32'h49);
      repeat (3) @(posedge mclk);
      apb(`IFPR_OFF_STATUS, 1'b0, 32'h0);
      check("ext high request", rd, 32'h3);
      apb(`IFPR_OFF_EXT_IRQ, 1'b1, 32'h09);
      repeat (3) @(posedge mclk);
      apb(`IFPR_OFF_STATUS, 1'b0, 32'h0);
      check("ext low request", rd, 32'h2);
      apb(`IFPR_OFF_EXT_IRQ, 1'b1, 32'h0);
      apb(`IFPR_OFF_FLAGS_ONE, 1'b1, 32'h0);
      repeat (3) @(posedge mclk);
      apb(`IFPR_OFF_STATUS, 1'b0, 32'h0);
      check("cleared request", rd, 32'h0);
      apb(12'h020, 1'b0, 32'h0);
      check("unmapped err", err, 32'h1);
      check("unmapped data", rd, 32'h0);
      $display("test vector done");
      end_of_test;
   end
endmodule // interrupt_flag_priority_regs_tb_top
